// ==== src/ext_bus_pkg.sv ====
package ext_bus_pkg;

	////////////////////////////////////////////////////////////////////////
	// arithmetic

	// least times round up to whole cycles, never below one cycle
	function automatic int cycles_ceil(input int time_ns, input int per_ns);
		int c;
		c = (time_ns + per_ns - 1) / per_ns;
		return (c < 1) ? 1 : c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// widths and reset values

	localparam int          ADDR_W       = 16;
	localparam int          DATA_W       = 16;
	localparam int          CNT_W        = 3;
	localparam logic [15:0] ADDR_RESET   = 16'h0000;
	localparam logic [15:0] DATA_RESET   = 16'h0000;
	localparam logic [2:0]  CNT_RESET    = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// timing, MCLK at 10 MHz

	localparam int CLK_PERIOD_NS = 100;
	localparam int T_SETUP_NS    = 100;
	localparam int T_STROBE_NS   = 250;
	localparam int T_HOLD_NS     = 100;

	localparam logic [2:0] SETUP_CYC  =
		3'(cycles_ceil(T_SETUP_NS, CLK_PERIOD_NS));
	localparam logic [2:0] STROBE_CYC =
		3'(cycles_ceil(T_STROBE_NS, CLK_PERIOD_NS));
	localparam logic [2:0] HOLD_CYC   =
		3'(cycles_ceil(T_HOLD_NS, CLK_PERIOD_NS));

	////////////////////////////////////////////////////////////////////////
	// types

	typedef enum logic [0:0] {
		SPACE_PROGRAM = 1'b0,
		SPACE_DATA    = 1'b1
	} space_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD   = 2'b11
	} bus_state_t;

	typedef struct packed {
		logic              write;
		space_t            space;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] stage1;
		logic [DATA_W-1:0] stage2;
	} sync_state_t;

	typedef struct packed {
		bus_state_t        st;
		logic [CNT_W-1:0]  cnt;
		logic              write;
		logic              mem_prog_n;
		logic              mem_data_n;
		logic              prog_pin_n;
		logic              data_pin_n;
		logic              rd_n;
		logic              wr_n;
		logic              data_oe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              ready;
		logic              done;
	} ctrl_state_t;

endpackage

// ==== src/ext_bus_strobes.sv ====
`timescale 1ns/1ps
module ext_bus_strobes (
	input  wire logic                           MCLK,
	input  wire logic                           SRST,
	input  wire logic                           REQ_VALID,
	input  wire ext_bus_pkg::bus_req_t          REQ,
	output logic                                REQ_READY,
	output logic                                DONE,
	output logic      [ext_bus_pkg::DATA_W-1:0] RDATA,
	input  wire logic                           PROG_SEL_IS_CS,
	input  wire logic                           DATA_SEL_IS_CS,
	input  wire logic                           CHIP_SELECT_OUT_0,
	input  wire logic                           CHIP_SELECT_OUT_1,
	output logic                                PROGRAM_SPACE_SELECT_N,
	output logic                                DATA_SPACE_SELECT_N,
	output logic                                READ_STROBE_N,
	output logic                                WRITE_STROBE_N,
	output logic      [ext_bus_pkg::ADDR_W-1:0] EXT_ADDRESS_BUS,
	input  wire logic [ext_bus_pkg::DATA_W-1:0] EXT_DATA_BUS_I,
	output logic      [ext_bus_pkg::DATA_W-1:0] EXT_DATA_BUS_O,
	output logic                                EXT_DATA_BUS_OE
);

	////////////////////////////////////////////////////////////////////////
	// state

	localparam ext_bus_pkg::ctrl_state_t RESET_STATE = '{
		st:         ext_bus_pkg::ST_IDLE,
		cnt:        ext_bus_pkg::CNT_RESET,
		write:      1'b0,
		mem_prog_n: 1'b1,
		mem_data_n: 1'b1,
		prog_pin_n: 1'b1,
		data_pin_n: 1'b1,
		rd_n:       1'b1,
		wr_n:       1'b1,
		data_oe:    1'b0,
		addr:       ext_bus_pkg::ADDR_RESET,
		wdata:      ext_bus_pkg::DATA_RESET,
		rdata:      ext_bus_pkg::DATA_RESET,
		ready:      1'b0,
		done:       1'b0
	};

	ext_bus_pkg::ctrl_state_t s_q;
	ext_bus_pkg::ctrl_state_t s_d;

	logic [ext_bus_pkg::DATA_W-1:0] data_in_sync;

	// pins are asynchronous to MCLK; sampled read data lags two cycles,
	// covered because the strobe lasts at least three
	ext_data_sync u_data_sync (
		.clk      (MCLK),
		.srst     (SRST),
		.pin_in   (EXT_DATA_BUS_I),
		.sync_out (data_in_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// every phase counter runs down to zero, then the phase ends
	function automatic logic cnt_end(
		input logic [ext_bus_pkg::CNT_W-1:0] c
	);
		return c == ext_bus_pkg::CNT_RESET;
	endfunction

	function automatic logic [ext_bus_pkg::CNT_W-1:0] cnt_step(
		input logic [ext_bus_pkg::CNT_W-1:0] c
	);
		return c - 3'h1;
	endfunction

	// a memory select is low only for its own space
	function automatic logic space_sel_n(
		input ext_bus_pkg::space_t sp,
		input ext_bus_pkg::space_t own
	);
		return sp != own;
	endfunction

	// chip-select mode hands the pin over; pin lags its inputs a cycle
	function automatic logic pin_sel_n(
		input logic use_cs,
		input logic cs_n,
		input logic mem_n
	);
		return use_cs ? cs_n : mem_n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			ext_bus_pkg::ST_IDLE:
			begin
				s_d.ready = 1'b1;
				if (REQ_VALID && s_q.ready)
				begin
					s_d.st    = ext_bus_pkg::ST_SETUP;
					s_d.cnt   = cnt_step(ext_bus_pkg::SETUP_CYC);
					s_d.ready = 1'b0;
					s_d.write = REQ.write;
					s_d.addr  = REQ.addr;
					s_d.wdata = REQ.wdata;
					// one select only, chosen by space
					s_d.mem_prog_n =
						space_sel_n(REQ.space, ext_bus_pkg::SPACE_PROGRAM);
					s_d.mem_data_n =
						space_sel_n(REQ.space, ext_bus_pkg::SPACE_DATA);
					// drive write data before the strobe falls
					s_d.data_oe = REQ.write;
				end
			end
			ext_bus_pkg::ST_SETUP:
			begin
				if (cnt_end(s_q.cnt))
				begin
					s_d.st   = ext_bus_pkg::ST_STROBE;
					s_d.cnt  = cnt_step(ext_bus_pkg::STROBE_CYC);
					// address and select already stable here
					s_d.rd_n = s_q.write;
					s_d.wr_n = !s_q.write;
				end
				else
				begin
					s_d.cnt = cnt_step(s_q.cnt);
				end
			end
			ext_bus_pkg::ST_STROBE:
			begin
				if (cnt_end(s_q.cnt))
				begin
					s_d.st   = ext_bus_pkg::ST_HOLD;
					s_d.cnt  = cnt_step(ext_bus_pkg::HOLD_CYC);
					s_d.rd_n = 1'b1;
					s_d.wr_n = 1'b1;
					if (!s_q.write)
					begin
						s_d.rdata = data_in_sync;
					end
				end
				else
				begin
					s_d.cnt = cnt_step(s_q.cnt);
				end
			end
			ext_bus_pkg::ST_HOLD:
			begin
				// data, address and select outlast the rising strobe
				if (cnt_end(s_q.cnt))
				begin
					s_d.st         = ext_bus_pkg::ST_IDLE;
					s_d.data_oe    = 1'b0;
					s_d.mem_prog_n = 1'b1;
					s_d.mem_data_n = 1'b1;
					s_d.ready      = 1'b1;
					s_d.done       = 1'b1;
				end
				else
				begin
					s_d.cnt = cnt_step(s_q.cnt);
				end
			end
			default:
			begin
				s_d = RESET_STATE;
			end
		endcase
		// chip-select function replaces the memory-space meaning
		s_d.prog_pin_n = pin_sel_n(PROG_SEL_IS_CS, CHIP_SELECT_OUT_0,
			s_d.mem_prog_n);
		s_d.data_pin_n = pin_sel_n(DATA_SEL_IS_CS, CHIP_SELECT_OUT_1,
			s_d.mem_data_n);
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			s_q <= RESET_STATE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from s_q

	assign REQ_READY              = s_q.ready;
	assign DONE                   = s_q.done;
	assign RDATA                  = s_q.rdata;
	assign PROGRAM_SPACE_SELECT_N = s_q.prog_pin_n;
	assign DATA_SPACE_SELECT_N    = s_q.data_pin_n;
	assign READ_STROBE_N          = s_q.rd_n;
	assign WRITE_STROBE_N         = s_q.wr_n;
	assign EXT_ADDRESS_BUS        = s_q.addr;
	assign EXT_DATA_BUS_O         = s_q.wdata;
	assign EXT_DATA_BUS_OE        = s_q.data_oe;

endmodule

// ==== src/ext_data_sync.sv ====
`timescale 1ns/1ps
module ext_data_sync (
	input  wire logic                         clk,
	input  wire logic                         srst,
	input  wire logic [ext_bus_pkg::DATA_W-1:0] pin_in,
	output logic      [ext_bus_pkg::DATA_W-1:0] sync_out
);

	ext_bus_pkg::sync_state_t s_q;
	ext_bus_pkg::sync_state_t s_d;

	// stage1 feeds stage2 only: keeps metastability off the logic
	always_comb
	begin
		s_d        = s_q;
		s_d.stage1 = pin_in;
		s_d.stage2 = s_q.stage1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stage2;

endmodule

// ==== verification/ext_bus_strobes_properties.sv ====
`timescale 1ns/1ps
module ext_bus_strobes_properties (
	input wire logic                  MCLK,
	input wire logic                  SRST,
	input wire logic                  REQ_VALID,
	input wire ext_bus_pkg::bus_req_t REQ,
	input wire logic                  REQ_READY,
	input wire logic                  DONE,
	input wire logic                  PROG_SEL_IS_CS,
	input wire logic                  DATA_SEL_IS_CS,
	input wire logic                  CHIP_SELECT_OUT_0,
	input wire logic                  CHIP_SELECT_OUT_1,
	input wire logic                  PROGRAM_SPACE_SELECT_N,
	input wire logic                  DATA_SPACE_SELECT_N,
	input wire logic                  READ_STROBE_N,
	input wire logic                  WRITE_STROBE_N,
	input wire logic [15:0]           EXT_ADDRESS_BUS,
	input wire logic [15:0]           EXT_DATA_BUS_O,
	input wire logic                  EXT_DATA_BUS_OE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	logic take;
	assign take = REQ_VALID && REQ_READY;

	a_strobe_excl: assert property (READ_STROBE_N || WRITE_STROBE_N)
		else $error("both strobes low");
	// pins follow the mode inputs one cycle late
	a_select_excl: assert property ($past(PROG_SEL_IS_CS)
		|| $past(DATA_SEL_IS_CS) || PROGRAM_SPACE_SELECT_N
		|| DATA_SPACE_SELECT_N)
		else $error("both selects low");
	a_read_walk: assert property (take && !REQ.write |->
		##1 READ_STROBE_N && !REQ_READY ##1 !READ_STROBE_N [*3]
		##1 READ_STROBE_N ##1 DONE && REQ_READY)
		else $error("read strobe sequence");
	a_write_walk: assert property (take && REQ.write |->
		##1 EXT_DATA_BUS_OE && WRITE_STROBE_N
		##1 (EXT_DATA_BUS_OE && !WRITE_STROBE_N) [*3]
		##1 EXT_DATA_BUS_OE ##1 !EXT_DATA_BUS_OE && DONE)
		else $error("write strobe sequence");
	a_read_float: assert property (!READ_STROBE_N |-> !EXT_DATA_BUS_OE)
		else $error("driving during read");
	a_addr_hold: assert property (take |-> ##1
		EXT_ADDRESS_BUS == $past(REQ.addr) ##1 $stable(EXT_ADDRESS_BUS) [*4])
		else $error("address not held");
	a_prog_select: assert property (take && !REQ.space &&
		!PROG_SEL_IS_CS |-> ##1 !PROGRAM_SPACE_SELECT_N [*5]
		##1 PROGRAM_SPACE_SELECT_N)
		else $error("program select timing");
	a_idle_float: assert property (REQ_READY |-> !EXT_DATA_BUS_OE)
		else $error("bus driven while idle");
	a_cs_route: assert property (PROG_SEL_IS_CS ##1 PROG_SEL_IS_CS |->
		PROGRAM_SPACE_SELECT_N == $past(CHIP_SELECT_OUT_0))
		else $error("chip select not routed");
	a_cs_route_data: assert property (DATA_SEL_IS_CS
		##1 DATA_SEL_IS_CS |-> DATA_SPACE_SELECT_N == $past(CHIP_SELECT_OUT_1))
		else $error("data chip select not routed");
	a_data_select: assert property (take && REQ.space &&
		!DATA_SEL_IS_CS |-> ##1 !DATA_SPACE_SELECT_N [*5]
		##1 DATA_SPACE_SELECT_N)
		else $error("data select timing");
	a_wdata_hold: assert property (take && REQ.write |-> ##1
		EXT_DATA_BUS_O == $past(REQ.wdata) ##1 $stable(EXT_DATA_BUS_O) [*4])
		else $error("write data not held");

	c_read: cover property (take && !REQ.write);
	c_write: cover property (take && REQ.write);
	c_cs: cover property (PROG_SEL_IS_CS && !PROGRAM_SPACE_SELECT_N);
	c_b2b: cover property (take && DONE);
endmodule

bind ext_bus_strobes ext_bus_strobes_properties chk (
	.MCLK                   (MCLK),
	.SRST                   (SRST),
	.REQ_VALID              (REQ_VALID),
	.REQ                    (REQ),
	.REQ_READY              (REQ_READY),
	.DONE                   (DONE),
	.PROG_SEL_IS_CS         (PROG_SEL_IS_CS),
	.DATA_SEL_IS_CS         (DATA_SEL_IS_CS),
	.CHIP_SELECT_OUT_0      (CHIP_SELECT_OUT_0),
	.CHIP_SELECT_OUT_1      (CHIP_SELECT_OUT_1),
	.PROGRAM_SPACE_SELECT_N (PROGRAM_SPACE_SELECT_N),
	.DATA_SPACE_SELECT_N    (DATA_SPACE_SELECT_N),
	.READ_STROBE_N          (READ_STROBE_N),
	.WRITE_STROBE_N         (WRITE_STROBE_N),
	.EXT_ADDRESS_BUS        (EXT_ADDRESS_BUS),
	.EXT_DATA_BUS_O         (EXT_DATA_BUS_O),
	.EXT_DATA_BUS_OE        (EXT_DATA_BUS_OE)
);

// ==== verification/ext_bus_strobes_test.sv ====
`timescale 1ns/1ps
module ext_bus_strobes_test;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  vld = 1'b0;
	ext_bus_pkg::bus_req_t req = '0;
	logic                  p_cs = 1'b0;
	logic                  d_cs = 1'b0;
	logic                  cs0 = 1'b1;
	logic                  cs1 = 1'b1;
	logic                  rdy, done, prog_n, data_n, rd_n, wr_n, oe;
	logic [15:0]           rdat, addr, dout, pd, dd;
	wire  [15:0]           bus = oe ? dout : (prog_n ? dd : pd);
	int                    error_cnt = 0;
	int                    check_count = 0;
	int                    cyc = 0;

	always #50 clk = ~clk;

	ext_bus_strobes uut (.MCLK(clk), .SRST(rst), .REQ_VALID(vld),
		.REQ(req), .REQ_READY(rdy), .DONE(done), .RDATA(rdat),
		.PROG_SEL_IS_CS(p_cs), .DATA_SEL_IS_CS(d_cs),
		.CHIP_SELECT_OUT_0(cs0), .CHIP_SELECT_OUT_1(cs1),
		.PROGRAM_SPACE_SELECT_N(prog_n), .DATA_SPACE_SELECT_N(data_n),
		.READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
		.EXT_ADDRESS_BUS(addr), .EXT_DATA_BUS_I(bus),
		.EXT_DATA_BUS_O(dout), .EXT_DATA_BUS_OE(oe));
	sram_model pm (.oe_n(rd_n), .we_n(wr_n), .cs_n(prog_n), .addr(addr),
		.din(bus), .dout(pd));
	sram_model dm (.oe_n(rd_n), .we_n(wr_n), .cs_n(data_n), .addr(addr),
		.din(bus), .dout(dd));

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, s, input logic [15:0] a, d);
		@(posedge clk);
		vld <= 1'b1;
		req <= {w, s, a, d};
		do @(posedge clk); while (rdy !== 1'b1);
		vld <= 1'b0;
		do @(posedge clk); while (done !== 1'b1);
	endtask

	task automatic t_rw;
		acc(1'b1, 1'b0, 16'h0012, 16'hA5C3);
		acc(1'b1, 1'b1, 16'h0012, 16'h3C5A);
		acc(1'b0, 1'b0, 16'h0012, 16'h0000);
		check(rdat, 16'hA5C3);
		acc(1'b0, 1'b1, 16'h0012, 16'h0000);
		check(rdat, 16'h3C5A);
		$display("t_rw done");
	endtask

	// second request waits on the port while the first runs
	task automatic t_b2b;
		@(posedge clk);
		vld <= 1'b1;
		req <= {1'b1, 1'b1, 16'hFFFF, 16'hFFFF};
		do @(posedge clk); while (rdy !== 1'b1);
		req <= {1'b1, 1'b1, 16'h0000, 16'h8001};
		repeat (3) @(posedge clk);
		check({15'h0000, rdy}, 16'h0000);
		do @(posedge clk); while (rdy !== 1'b1);
		vld <= 1'b0;
		acc(1'b0, 1'b1, 16'hFFFF, 16'h0000);
		check(rdat, 16'hFFFF);
		acc(1'b0, 1'b1, 16'h0000, 16'h0000);
		check(rdat, 16'h8001);
		$display("t_b2b done");
	endtask

	task automatic t_cs;
		@(posedge clk);
		p_cs <= 1'b1;
		d_cs <= 1'b1;
		cs0 <= 1'b0;
		repeat (3) @(posedge clk);
		check({14'h0000, prog_n, data_n}, 16'h0001);
		cs0 <= 1'b1;
		cs1 <= 1'b0;
		repeat (3) @(posedge clk);
		check({14'h0000, prog_n, data_n}, 16'h0002);
		cs1 <= 1'b1;
		repeat (2) @(posedge clk);
		p_cs <= 1'b0;
		d_cs <= 1'b0;
		$display("t_cs done");
	endtask

	// reset in mid-write frees the pins; next access must still work
	task automatic t_mid_rst;
		@(posedge clk);
		vld <= 1'b1;
		req <= {1'b1, 1'b0, 16'h00AA, 16'h1234};
		do @(posedge clk); while (rdy !== 1'b1);
		vld <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		check({prog_n, data_n, rd_n, wr_n, oe, 11'h000}, 16'hF000);
		check(addr, 16'h0000);
		rst <= 1'b0;
		acc(1'b0, 1'b0, 16'h0012, 16'h0000);
		check(rdat, 16'hA5C3);
		$display("t_mid_rst done");
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 600)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		check({prog_n, data_n, rd_n, wr_n, oe, 11'h000}, 16'hF000);
		check(addr, 16'h0000);
		$display("t_reset done");
		t_rw();
		t_b2b();
		t_cs();
		t_mid_rst();
		give_verdict();
	end
endmodule

// ==== verification/sram_model.sv ====
`timescale 1ns/1ps
module sram_model (
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        cs_n,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] din,
	output logic      [15:0] dout
);
	logic [15:0] mem [0:255];

	always @(posedge we_n)
		if (!cs_n)
			mem[addr[7:0]] <= din;
	// released lines flip, so a stale copy never passes
	always @(oe_n or cs_n or addr)
		if (!oe_n && !cs_n)
			dout = mem[addr[7:0]];
		else
			dout = ~dout;
endmodule
